/* File: rtl/stoif_map.svh */
`ifndef STOIF_MAP_SVH
`define STOIF_MAP_SVH

// Register offsets (byte addresses)
`define STOIF_REG_CTRL 8'h00
`define STOIF_REG_STAT 8'h04
`define STOIF_REG_IRQ_STAT 8'h08
`define STOIF_REG_IRQ_CLR 8'h0C
`define STOIF_REG_IRQ_EN 8'h10
`define STOIF_REG_ADDR 8'h14
`define STOIF_REG_DIAG 8'h18
`define STOIF_REG_FRAME_IN 8'h1C
`define STOIF_REG_FRAME_OUT 8'h20
`define STOIF_REG_LOCAL_IN 8'h24

// CTRL fields
`define STOIF_CTRL_APP_LOADED 0
`define STOIF_CTRL_PATH1 1
`define STOIF_CTRL_PATH2 2
`define STOIF_CTRL_ERR_ACK 3
`define STOIF_CTRL_STAGE 4
`define STOIF_CTRL_GROUP_ERR 5

// Frame layout
`define STOIF_FRAME_BYTES 7
`define STOIF_USAGE_BYTES 2
`define STOIF_FRAME_W 56
`define STOIF_USAGE_W 16

// Diagnostics
`define STOIF_DIAG_N 16
`define STOIF_DIAG_BASE 16'hD300
`define STOIF_DIAG_DEPTH 8

// Reset values
`define STOIF_SAFE_ADDR_RST 16'h0001
`define STOIF_CTRL_RST 32'h0000_0000

// Interrupt bits
`define STOIF_IRQ_DIAG 0
`define STOIF_IRQ_PATH_ERR 1
`define STOIF_IRQ_TO_REQ 2

`endif

/* File: rtl/stoif_pkg.sv */
package stoif_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } stoif_bus_req_t;

    typedef struct packed {
        logic path_one;
        logic path_two;
        logic err_ack;
        logic stage;
        logic group_err;
    } stoif_local_out_t;

    typedef enum logic [1:0] {
        STOIF_IDLE,
        STOIF_SAFE,
        STOIF_RUN
    } stoif_state_t;
endpackage : stoif_pkg

/* File: rtl/stoif_diag_log.sv */
`timescale 1ns/1ps
`include "stoif_map.svh"
module stoif_diag_log
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [15:0] trig,
    output logic [15:0] edge_seen,
    output logic [15:0] last_code,
    output logic [7:0] count
);
    logic [15:0] prev_q;
    logic [15:0] prev_d;
    logic [15:0] code_q;
    logic [15:0] code_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [15:0] fall;

    // Per-trigger falling edge against the previous cycle
    genvar g;
    generate
        for (g = 0; g < `STOIF_DIAG_N; g = g + 1)
        begin : g_fall
            assign fall[g] = prev_q[g] & ~trig[g];
        end
    endgenerate

    always_comb
    begin
        prev_d = trig;
        code_d = code_q;
        cnt_d = cnt_q;
        // Simultaneous falls: lowest trigger's code wins, count still adds one
        for (int i = `STOIF_DIAG_N - 1; i >= 0; i--)
        begin
            if (fall[i])
            begin
                code_d = `STOIF_DIAG_BASE + 16'(i);
            end
        end
        if (|fall)
        begin
            cnt_d = cnt_q + 8'h01;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            prev_q <= 16'h0000;
            code_q <= 16'h0000;
            cnt_q <= 8'h00;
        end
        else
        begin
            prev_q <= prev_d;
            code_q <= code_d;
            cnt_q <= cnt_d;
        end
    end

    assign edge_seen = fall;
    assign last_code = code_q;
    assign count = cnt_q;

    AST_DIAG_CODE: assert property (@(posedge sys_clk) disable iff (rst)
        fall[0] |=> code_q == 16'hD300)
        else $error("first trigger code wrong");
    AST_DIAG_LAST: assert property (@(posedge sys_clk) disable iff (rst)
        (fall == 16'h8000) |=> code_q == 16'hD30F)
        else $error("last trigger code wrong");
    AST_DIAG_EDGE: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(trig[3]) |-> fall[3])
        else $error("falling edge missed");
endmodule : stoif_diag_log

/* File: rtl/stoif_top.sv */
// Notes on behaviour
// - Torque-off request true keeps outputs enabled; false forces safe state.
// - Status bit to drive: true enabled, false torque-off safe state.
// - Input frame is 7 bytes with 2 bytes usage data.
// - Output frame is 7 bytes with 2 bytes usage data.
// - Safe node address resets to 1.
// - No safety application loaded holds both switch-off paths and the output stage off.
// - Error flag true when either switch-off path reports an error.
// - Axis-state flag true while the axis is enabled.
// - Run and error-ack requests from drive word passed as local inputs.
// - Two independent bits each enable their own switch-off path.
// - Acknowledge bit clears an error latched in the switch-off paths.
// - Output-stage enable bit enables drive power stage when true.
// - Group error bit reported to drive firmware.
// - Falling trigger edge logs one code; first trigger logs 0xD300.
// - Sixteen triggers; last logs 0xD30F.
`timescale 1ns/1ps
`include "stoif_map.svh"
module stoif_top
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [55:0] frame_in,
    output logic [55:0] frame_out,
    input wire logic path_one_fault,
    input wire logic path_two_fault,
    input wire logic drive_run_request,
    input wire logic drive_error_ack_request,
    input wire logic [15:0] drive_cmd,
    output logic switch_off_path_one_enable,
    output logic switch_off_path_two_enable,
    output logic path_error_acknowledge,
    output logic output_stage_enable,
    output logic group_error_to_drive,
    output logic torque_off_status_to_drive,
    output logic path_error_flag,
    output logic axis_enabled_flag,
    output logic irq
);
    stoif_pkg::stoif_bus_req_t bus;
    stoif_pkg::stoif_local_out_t lo_q;
    stoif_pkg::stoif_local_out_t lo_d;
    stoif_pkg::stoif_state_t st_q;
    stoif_pkg::stoif_state_t st_d;
    logic [5:0] ctrl_q;
    logic [5:0] ctrl_d;
    logic [15:0] addr_q;
    logic [15:0] addr_d;
    logic [2:0] ist_q;
    logic [2:0] ist_d;
    logic [2:0] ien_q;
    logic [2:0] ien_d;
    logic err_q;
    logic err_d;
    logic req_prev_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [55:0] fout_q;
    logic [55:0] fout_d;
    logic torque_off_request;
    logic [15:0] diag_edges;
    logic [15:0] diag_code;
    logic [7:0] diag_count;
    logic [2:0] events;

    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // Usage data sits in the low two bytes; the rest is protocol overhead
    assign torque_off_request = frame_in[0];

    // Diagnostic triggers take all sixteen bits of drive_cmd
    stoif_diag_log u_diag
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .trig(drive_cmd),
        .edge_seen(diag_edges),
        .last_code(diag_code),
        .count(diag_count)
    );

    // Safety state: safe unless an application is loaded, STO is lifted and no path error is latched
    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            stoif_pkg::STOIF_IDLE:
            begin
                if (ctrl_q[`STOIF_CTRL_APP_LOADED])
                begin
                    st_d = stoif_pkg::STOIF_SAFE;
                end
            end
            stoif_pkg::STOIF_SAFE:
            begin
                if (!ctrl_q[`STOIF_CTRL_APP_LOADED])
                begin
                    st_d = stoif_pkg::STOIF_IDLE;
                end
                else if (torque_off_request && !err_q)
                begin
                    st_d = stoif_pkg::STOIF_RUN;
                end
            end
            stoif_pkg::STOIF_RUN:
            begin
                if (!ctrl_q[`STOIF_CTRL_APP_LOADED])
                begin
                    st_d = stoif_pkg::STOIF_IDLE;
                end
                else if (!torque_off_request || err_q)
                begin
                    st_d = stoif_pkg::STOIF_SAFE;
                end
            end
            default:
            begin
                st_d = stoif_pkg::STOIF_IDLE;
            end
        endcase
    end

    // Latched path error; a new fault beats the acknowledge
    always_comb
    begin
        err_d = err_q;
        if (lo_q.err_ack)
        begin
            err_d = 1'b0;
        end
        if (path_one_fault || path_two_fault)
        begin
            err_d = 1'b1;
        end
    end

    // Path and stage outputs only pass while running, so safe state overrides software
    // The load bit gates them too: the state lags it by a cycle, and an
    // unloaded application must not leave a path or the stage on meanwhile
    always_comb
    begin
        lo_d.path_one = (st_q == stoif_pkg::STOIF_RUN)
            && ctrl_q[`STOIF_CTRL_APP_LOADED]
            && ctrl_q[`STOIF_CTRL_PATH1];
        lo_d.path_two = (st_q == stoif_pkg::STOIF_RUN)
            && ctrl_q[`STOIF_CTRL_APP_LOADED]
            && ctrl_q[`STOIF_CTRL_PATH2];
        lo_d.err_ack = ctrl_q[`STOIF_CTRL_ERR_ACK];
        lo_d.stage = (st_q == stoif_pkg::STOIF_RUN)
            && ctrl_q[`STOIF_CTRL_APP_LOADED]
            && ctrl_q[`STOIF_CTRL_STAGE];
        lo_d.group_err = ctrl_q[`STOIF_CTRL_GROUP_ERR] || err_q;
    end

    // Output frame: byte 0 bit 0 reports torque-off state
    always_comb
    begin
        fout_d = 56'h00_0000_0000_0000;
        fout_d[0] = (st_q == stoif_pkg::STOIF_RUN);
    end

    assign events[`STOIF_IRQ_DIAG] = |diag_edges;
    assign events[`STOIF_IRQ_PATH_ERR] = err_d & ~err_q;
    assign events[`STOIF_IRQ_TO_REQ] = req_prev_q & ~torque_off_request;

    // Register writes; error-ack bit self-clears so it acts as a pulse
    always_comb
    begin
        ctrl_d = ctrl_q;
        ctrl_d[`STOIF_CTRL_ERR_ACK] = 1'b0;
        addr_d = addr_q;
        ien_d = ien_q;
        ist_d = ist_q;
        if (bus.wr)
        begin
            unique case (bus.addr)
                `STOIF_REG_CTRL: ctrl_d = bus.wdata[5:0];
                `STOIF_REG_IRQ_CLR: ist_d = ist_q & ~bus.wdata[2:0];
                `STOIF_REG_IRQ_EN: ien_d = bus.wdata[2:0];
                `STOIF_REG_ADDR: addr_d = bus.wdata[15:0];
                default: ist_d = ist_q;
            endcase
        end
        ist_d = ist_d | events;
    end

    // Read mux; unmapped addresses read zero
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (bus.rd)
        begin
            unique case (bus.addr)
                `STOIF_REG_CTRL: rdata_d = {26'h000_0000, ctrl_q};
                `STOIF_REG_STAT: rdata_d = {24'h00_0000, diag_count[3:0],
                    err_q, axis_enabled_flag, st_q};
                `STOIF_REG_IRQ_STAT: rdata_d = {29'h0000_0000, ist_q};
                `STOIF_REG_IRQ_EN: rdata_d = {29'h0000_0000, ien_q};
                `STOIF_REG_ADDR: rdata_d = {16'h0000, addr_q};
                `STOIF_REG_DIAG: rdata_d = {diag_count, 8'h00, diag_code};
                `STOIF_REG_FRAME_IN: rdata_d = {16'h0000,
                    frame_in[`STOIF_USAGE_W-1:0]};
                `STOIF_REG_FRAME_OUT: rdata_d = {16'h0000,
                    fout_q[`STOIF_USAGE_W-1:0]};
                `STOIF_REG_LOCAL_IN: rdata_d = {28'h000_0000,
                    drive_error_ack_request, drive_run_request,
                    axis_enabled_flag, path_error_flag};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_q <= stoif_pkg::STOIF_IDLE;
            ctrl_q <= 6'h00;
            addr_q <= `STOIF_SAFE_ADDR_RST;
            ist_q <= 3'h0;
            ien_q <= 3'h0;
            err_q <= 1'b0;
            req_prev_q <= 1'b0;
            lo_q <= '0;
            rdata_q <= 32'h0000_0000;
            fout_q <= 56'h00_0000_0000_0000;
        end
        else
        begin
            st_q <= st_d;
            ctrl_q <= ctrl_d;
            addr_q <= addr_d;
            ist_q <= ist_d;
            ien_q <= ien_d;
            err_q <= err_d;
            req_prev_q <= torque_off_request;
            lo_q <= lo_d;
            rdata_q <= rdata_d;
            fout_q <= fout_d;
        end
    end

    assign switch_off_path_one_enable = lo_q.path_one;
    assign switch_off_path_two_enable = lo_q.path_two;
    assign path_error_acknowledge = lo_q.err_ack;
    assign output_stage_enable = lo_q.stage;
    assign group_error_to_drive = lo_q.group_err;
    assign torque_off_status_to_drive = fout_q[0];
    assign path_error_flag = err_q;
    assign axis_enabled_flag = (st_q == stoif_pkg::STOIF_RUN);
    assign frame_out = fout_q;
    assign reg_rdata = rdata_q;
    assign irq = |(ist_q & ien_q);

    AST_SAFE_OFF: assert property (@(posedge sys_clk) disable iff (rst)
        !torque_off_request |-> ##2 !switch_off_path_one_enable
        && !switch_off_path_two_enable)
        else $error("paths not off after torque-off");
    AST_RUN_REQ: assert property (@(posedge sys_clk) disable iff (rst)
        axis_enabled_flag |-> $past(torque_off_request))
        else $error("running without torque-off request");
    AST_STATUS: assert property (@(posedge sys_clk) disable iff (rst)
        torque_off_status_to_drive == $past(axis_enabled_flag))
        else $error("status bit mismatch");
    AST_ADDR_RST: assert property (@(posedge sys_clk)
        $fell(rst) |-> addr_q == 16'h0001)
        else $error("safe address not one");
    AST_NO_APP: assert property (@(posedge sys_clk) disable iff (rst)
        !ctrl_q[0] [*2] |-> !output_stage_enable && !axis_enabled_flag)
        else $error("outputs on without application");
    AST_STAGE_APP: assert property (@(posedge sys_clk) disable iff (rst)
        output_stage_enable |-> $past(ctrl_q[`STOIF_CTRL_APP_LOADED]))
        else $error("stage enabled without application");
    AST_ERR_SET: assert property (@(posedge sys_clk) disable iff (rst)
        (path_one_fault || path_two_fault) |=> path_error_flag)
        else $error("path error not flagged");
    AST_ERR_SAFE: assert property (@(posedge sys_clk) disable iff (rst)
        path_error_flag |=> !axis_enabled_flag)
        else $error("axis still enabled with path error");
    AST_PATHS_RUN: assert property (@(posedge sys_clk) disable iff (rst)
        switch_off_path_one_enable || switch_off_path_two_enable
        |-> $past(axis_enabled_flag))
        else $error("switch-off path enabled outside run");
    AST_ERR_ACK: assert property (@(posedge sys_clk) disable iff (rst)
        path_error_acknowledge && !path_one_fault && !path_two_fault
        |=> !path_error_flag)
        else $error("acknowledge did not clear error");
    AST_GROUP: assert property (@(posedge sys_clk) disable iff (rst)
        path_error_flag |=> group_error_to_drive)
        else $error("group error missing");
    AST_STAGE: assert property (@(posedge sys_clk) disable iff (rst)
        output_stage_enable |-> $past(axis_enabled_flag))
        else $error("stage enabled outside run");
    AST_IRQ: assert property (@(posedge sys_clk) disable iff (rst)
        path_error_flag && !$past(path_error_flag) && ien_q[1] |-> irq)
        else $error("interrupt missing");
endmodule : stoif_top

/* File: dv/stoif_ctrl_model.sv */
`timescale 1ns/1ps
module stoif_ctrl_model
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic run_req,
    input wire logic [1:0] lag,
    input wire logic [55:0] frame_out,
    output logic [55:0] frame_in,
    output logic status_seen
);
    logic [3:0] req_q;
    logic [39:0] seq_q;
    // Overhead bytes churn every cycle, so the card must not lean on them
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            req_q <= 4'h0;
            seq_q <= 40'h00_0000_0000;
        end
        else
        begin
            req_q <= {req_q[2:0], run_req};
            seq_q <= seq_q + 40'h13_579B_DF01;
        end
    end
    // Lag picks a prompt or a slow controller
    assign frame_in = {seq_q, 15'h0000, req_q[lag]};
    assign status_seen = frame_out[0];
endmodule : stoif_ctrl_model

/* File: dv/safe_torque_off_interface_test.sv */
`timescale 1ns/1ps
`include "stoif_map.svh"
`define check_eq(nm, exp, got) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            n_errors++; \
            $display("[FAIL] %s exp %h got %h", nm, exp, got); \
        end \
    end
module safe_torque_off_interface_test;
    logic sys_clk = 1'b0;
    logic rst, reg_wr, reg_rd, path_one_fault, path_two_fault;
    logic drive_run_request, drive_error_ack_request, run_req;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd;
    logic [55:0] frame_in, frame_out;
    logic [15:0] drive_cmd;
    logic [1:0] lag;
    logic p1_en, p2_en, ack, stage_en, grp, sts, err, axis, irq, seen;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;

    stoif_top stoif_top_i (.sys_clk(sys_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_in(frame_in),
        .frame_out(frame_out), .path_one_fault(path_one_fault),
        .path_two_fault(path_two_fault),
        .drive_run_request(drive_run_request),
        .drive_error_ack_request(drive_error_ack_request),
        .drive_cmd(drive_cmd), .switch_off_path_one_enable(p1_en),
        .switch_off_path_two_enable(p2_en), .path_error_acknowledge(ack),
        .output_stage_enable(stage_en), .group_error_to_drive(grp),
        .torque_off_status_to_drive(sts), .path_error_flag(err),
        .axis_enabled_flag(axis), .irq(irq));
    stoif_ctrl_model stoif_ctrl_model_i (.sys_clk(sys_clk), .rst(rst),
        .run_req(run_req), .lag(lag), .frame_out(frame_out),
        .frame_in(frame_in), .status_seen(seen));

    always #10 sys_clk = ~sys_clk;

    // The whole run needs well under a thousand cycles
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            n_errors++;
            conclude();
        end
    end

    task automatic conclude();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rdr(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rdr

    task automatic t_reset();
        rdr(`STOIF_REG_ADDR, rd);
        `check_eq("safe addr", 32'h0000_0001, rd)
        `check_eq("outs", 6'h00, {p1_en, p2_en, stage_en, sts, axis, grp})
        `check_eq("frame out", 56'h0, frame_out)
        rdr(8'h40, rd);
        `check_eq("unmapped", 32'h0000_0000, rd)
    endtask : t_reset

    task automatic t_noapp();
        run_req <= 1'b1;
        wr(`STOIF_REG_CTRL, 32'h0000_0016);
        cyc(8);
        `check_eq("no app", 5'h00, {p1_en, p2_en, stage_en, sts, axis})
    endtask : t_noapp

    task automatic t_run();
        logic [7:0] cv [3] = '{8'h15, 8'h13, 8'h07};
        logic [2:0] ev [3] = '{3'b011, 3'b101, 3'b110};
        wr(`STOIF_REG_CTRL, 32'h0000_0017);
        cyc(8);
        `check_eq("run", 5'h1F, {p1_en, p2_en, stage_en, sts, axis})
        `check_eq("stage", 1'b1, stage_en)
        rdr(`STOIF_REG_STAT, rd);
        `check_eq("stat", 8'h06, rd[7:0])
        rdr(`STOIF_REG_FRAME_IN, rd);
        `check_eq("frame in", 32'h0000_0001, rd)
        `check_eq("seen", 1'b1, seen)
        `check_eq("frame hi", 55'h0, frame_out[55:1])
        rdr(`STOIF_REG_FRAME_OUT, rd);
        `check_eq("frame reg", 32'h0000_0001, rd)
        for (int k = 0; k < 3; k++)
        begin
            wr(`STOIF_REG_CTRL, {24'h00_0000, cv[k]});
            cyc(4);
            `check_eq("paths", ev[k], {p1_en, p2_en, stage_en})
        end
        lag <= 2'd3;
        wr(`STOIF_REG_CTRL, 32'h0000_0017);
        run_req <= 1'b0;
        cyc(10);
        `check_eq("safe", 5'h00, {p1_en, p2_en, stage_en, sts, axis})
        rdr(`STOIF_REG_IRQ_STAT, rd);
        `check_eq("to fell", 1'b1, rd[`STOIF_IRQ_TO_REQ])
        run_req <= 1'b1;
        lag <= 2'd0;
    endtask : t_run

    task automatic t_local();
        @(posedge sys_clk);
        drive_run_request <= 1'b1;
        rdr(`STOIF_REG_LOCAL_IN, rd);
        `check_eq("local run", 2'b01, rd[3:2])
        @(posedge sys_clk);
        drive_run_request <= 1'b0;
        drive_error_ack_request <= 1'b1;
        rdr(`STOIF_REG_LOCAL_IN, rd);
        `check_eq("local ack", 2'b10, rd[3:2])
        @(posedge sys_clk);
        drive_error_ack_request <= 1'b0;
    endtask : t_local

    task automatic t_err();
        int n;
        wr(`STOIF_REG_IRQ_EN, 32'h0000_0002);
        for (int p = 0; p < 2; p++)
        begin
            wr(`STOIF_REG_CTRL, 32'h0000_0017);
            cyc(8);
            @(posedge sys_clk);
            {path_two_fault, path_one_fault} <= p ? 2'b10 : 2'b01;
            cyc(2);
            @(posedge sys_clk);
            {path_two_fault, path_one_fault} <= 2'b00;
            cyc(4);
            `check_eq("err flag", 1'b1, err)
            `check_eq("grp err", 1'b1, grp)
            `check_eq("err safe", 3'h0, {p1_en, p2_en, stage_en})
            `check_eq("irq on", 1'b1, irq)
            wr(`STOIF_REG_IRQ_EN, 32'h0000_0000);
            cyc(2);
            `check_eq("irq masked", 1'b0, irq)
            wr(`STOIF_REG_IRQ_EN, 32'h0000_0002);
            wr(`STOIF_REG_IRQ_CLR, 32'h0000_0002);
            cyc(2);
            `check_eq("irq clr", 1'b0, irq)
            wr(`STOIF_REG_CTRL, 32'h0000_001F);
            n = 0;
            repeat (6)
            begin
                cyc(1);
                n += ack;
            end
            `check_eq("ack pulse", 1, n)
            `check_eq("err gone", 2'b00, {err, grp})
        end
        wr(`STOIF_REG_CTRL, 32'h0000_0020);
        cyc(3);
        `check_eq("grp bit", 1'b1, grp)
    endtask : t_err

    task automatic t_diag();
        for (int i = 0; i < 16; i++)
        begin
            @(posedge sys_clk);
            drive_cmd <= 16'h0001 << i;
            cyc(2);
            rdr(`STOIF_REG_DIAG, rd);
            `check_eq("no rise log", 8'(i), rd[31:24])
            @(posedge sys_clk);
            drive_cmd <= 16'h0000;
            cyc(3);
            rdr(`STOIF_REG_DIAG, rd);
            `check_eq("diag", {8'(i + 1), 8'h00, 16'hD300 + 16'(i)}, rd)
        end
        `check_eq("last code", 16'hD30F, rd[15:0])
    endtask : t_diag

    task automatic t_reserved();
        wr(`STOIF_REG_CTRL, 32'hFFFF_FFC0);
        cyc(8);
        `check_eq("rsvd", 4'h0, {p1_en, p2_en, stage_en, grp})
    endtask : t_reserved

    initial
    begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        path_one_fault = 1'b0;
        path_two_fault = 1'b0;
        drive_run_request = 1'b0;
        drive_error_ack_request = 1'b0;
        drive_cmd = 16'h0000;
        run_req = 1'b0;
        lag = 2'd0;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_noapp();
        t_run();
        t_local();
        t_err();
        t_diag();
        t_reserved();
        conclude();
    end
endmodule : safe_torque_off_interface_test
